// [pfmg_map.svh]
// pfmg_map.svh: offsets, field positions and reset values of the
// multipurpose pin registers.
// assumes: 8-bit registers on an 8-bit register address, one clock.
//
// Operation
// - input-only pin disabled at enable bit 1 = 0, input function at 1.
// - in SPI mode input-only pin is chip select; its enable is ignored.
// - value bit 7 sets bidirectional pin A level when it is an output.
// - value bit 6 sets bidirectional pin B level when it is an output.
// - value bit 5 sets output-only pin level when it is an output.
// - read-only bits 3, 2, 1 return sampled A, B, input-only levels.
// - reserved bits read zero; software writes reserved bits with reset value.
// - bits 6-5 pick controller clock: off, pin A, pin B, input-only pin.
// - bits 4-2 pick primary second data input source; codes 6-7 reserved.
// - routing bit 1 picks dedicated or secondary bit clock for primary port.
// - routing bit 0 picks dedicated or secondary frame sync for primary port.
// - serial out function bits 7-4 reset to 5; 0 off, 1 in, 2 GPO.
// - codes 3, 4, 11 carry interrupt, PDM clock, general clock output.
// - codes 6-8 carry second/secondary data outputs; 9, 10 secondary clocks.
// - code 12 drives primary and secondary data outputs multiplexed.
// - code 13 reuses serial out pin as loopback serial data input.
// - serial out bit 3 is the level driven as general-purpose output.
// - drive bits 2-0 choose output style, reset 2; codes 6-7 reserved.
`ifndef PFMG_MAP_SVH
`define PFMG_MAP_SVH

// ====================================================================
// register offsets
`define PFMG_ADDR_IN_EN      8'h0d
`define PFMG_ADDR_VALUES     8'h0e
`define PFMG_ADDR_ROUTING    8'h0f
`define PFMG_ADDR_SOUT       8'h10

// ====================================================================
// reset values
`define PFMG_RST_IN_EN       8'h00
`define PFMG_RST_VALUES      8'h00
`define PFMG_RST_ROUTING     8'h00
`define PFMG_RST_SOUT        8'h52

// ====================================================================
// writable bit masks, reserved and read-only bits cleared
`define PFMG_WMASK_IN_EN     8'h02
`define PFMG_WMASK_VALUES    8'he0
`define PFMG_WMASK_ROUTING   8'h7f
`define PFMG_WMASK_SOUT      8'hff

// ====================================================================
// field positions
`define PFMG_IN_EN_BIT       1
`define PFMG_A_LVL_BIT       7
`define PFMG_B_LVL_BIT       6
`define PFMG_O_LVL_BIT       5
`define PFMG_A_MON_BIT       3
`define PFMG_B_MON_BIT       2
`define PFMG_I_MON_BIT       1
`define PFMG_CONTROLLER_CLOCK_HI         6
`define PFMG_CONTROLLER_CLOCK_LO         5
`define PFMG_DIN2_HI         4
`define PFMG_DIN2_LO         2
`define PFMG_BCLK_BIT        1
`define PFMG_FSYNC_BIT       0
`define PFMG_FN_HI           7
`define PFMG_FN_LO           4
`define PFMG_SLVL_BIT        3
`define PFMG_DRV_HI          2
`define PFMG_DRV_LO          0

// ====================================================================
// synchroniser lane positions for pin-level inputs
`define PFMG_SY_A            0
`define PFMG_SY_B            1
`define PFMG_SY_I            2
`define PFMG_SY_SOUT         3
`define PFMG_SY_PDIN         4
`define PFMG_SY_PBCLK        5
`define PFMG_SY_PFSYNC       6
`define PFMG_SY_SBCLK        7
`define PFMG_SY_SFSYNC       8
`define PFMG_SY_WIDTH        9

`endif

// [pfmg_pkg.sv]
// pfmg_pkg.sv: types of the multipurpose pin block.
// assumes: pfmg_map.svh holds the register offsets, reset values, masks and field positions.
package pfmg_pkg;

  // serial out pin function codes
  typedef enum logic [3:0] {
    PFMG_FN_OFF      = 4'h0,
    PFMG_FN_INPUT    = 4'h1,
    PFMG_FN_GPO      = 4'h2,
    PFMG_FN_IRQ      = 4'h3,
    PFMG_FN_PDM_CLOCK_OUTPUT   = 4'h4,
    PFMG_FN_PDOUT    = 4'h5,
    PFMG_FN_PDOUT2   = 4'h6,
    PFMG_FN_SDOUT    = 4'h7,
    PFMG_FN_SDOUT2   = 4'h8,
    PFMG_FN_SBCLK    = 4'h9,
    PFMG_FN_SFSYNC   = 4'ha,
    PFMG_FN_GENERAL_CLOCK_OUTPUT   = 4'hb,
    PFMG_FN_MUXED    = 4'hc,
    PFMG_FN_LOOPBACK = 4'hd,
    PFMG_FN_RSVD_E   = 4'he,
    PFMG_FN_RSVD_F   = 4'hf
  } pfmg_sout_fn_e;

  // serial out pin drive styles
  typedef enum logic [2:0] {
    PFMG_DRV_HIZ       = 3'h0,
    PFMG_DRV_PUSHPULL  = 3'h1,
    PFMG_DRV_LOW_WEAKH = 3'h2,
    PFMG_DRV_LOW_HIZH  = 3'h3,
    PFMG_DRV_WEAKL_HI  = 3'h4,
    PFMG_DRV_HIZL_HI   = 3'h5,
    PFMG_DRV_RSVD_6    = 3'h6,
    PFMG_DRV_RSVD_7    = 3'h7
  } pfmg_drive_e;

  // whole state of the top module
  typedef struct packed {
    logic          in_pin_en;
    logic          a_lvl;
    logic          b_lvl;
    logic          o_lvl;
    logic [1:0]    controller_clock_src;
    logic [2:0]    din2_src;
    logic          bclk_src;
    logic          fsync_src;
    pfmg_sout_fn_e sout_fn;
    logic          sout_lvl;
    pfmg_drive_e   sout_drv;
    logic [7:0]    rdata;
    logic          a_pin;
    logic          a_oe;
    logic          b_pin;
    logic          b_oe;
    logic          o_pin;
    logic          o_oe;
    logic          s_pin;
    logic          s_oe;
    logic          s_weak;
    logic          controller_clock;
    logic          din2;
    logic          bclk;
    logic          fsync;
    logic          cs_n;
    logic          loop_din;
  } pfmg_state_s;

endpackage

// [pfmg_pins_if.sv]
// pfmg_pins_if.sv: raw and synchronised pin levels between the
// synchroniser and the pin logic.
// assumes: widths from pfmg_map.svh.
`timescale 1ns/1ps
`include "pfmg_map.svh"

interface pfmg_pins_if;
  logic [`PFMG_SY_WIDTH-1:0] raw;
  logic [`PFMG_SY_WIDTH-1:0] synced;

  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface

// [pfmg_sync.sv]
// pfmg_sync.sv: two-flop synchroniser, one lane per pin level.
// assumes: single clock, synchronous active-high reset.
`timescale 1ns/1ps

module pfmg_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  pfmg_pins_if.sync pins
);

  // elaboration check on lane count
  if (WIDTH < 1) begin : g_bad_width
    $error("pfmg_sync: WIDTH must be at least 1");
  end

  // first stage read only by second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_lane
    logic meta_reg;
    logic stable_reg;
    always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
        meta_reg   <= 1'b0;
        stable_reg <= 1'b0;
      end else begin
        meta_reg   <= pins.raw[i];
        stable_reg <= meta_reg;
      end
    end
    assign pins.synced[i] = stable_reg;
  end

endmodule

// [pfmg_top.sv]
// pfmg_top.sv: multipurpose pin configuration, value and routing logic.
// assumes: register port driven by the control interface on the same
// clock; pin-level inputs are asynchronous; function selects of the
// bidirectional and output-only pins come from elsewhere.
`timescale 1ns/1ps
`include "pfmg_map.svh"

module pfmg_top (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  output wire logic [7:0] reg_rdata_out,
  // control interface mode
  input  wire logic       spi_mode_in,
  // function selects of pins configured elsewhere
  input  wire logic       bidir_a_is_gpo_in,
  input  wire logic       bidir_a_is_gpi_in,
  input  wire logic       bidir_b_is_gpo_in,
  input  wire logic       bidir_b_is_gpi_in,
  input  wire logic       output_only_is_gpo_in,
  // pins
  input  wire logic       bidir_pin_a_in,
  output wire logic       bidir_pin_a_out,
  output wire logic       bidir_pin_a_oe_out,
  input  wire logic       bidir_pin_b_in,
  output wire logic       bidir_pin_b_out,
  output wire logic       bidir_pin_b_oe_out,
  output wire logic       output_only_pin_out,
  output wire logic       output_only_pin_oe_out,
  input  wire logic       input_only_pin_in,
  input  wire logic       serial_out_pin_in,
  output wire logic       serial_out_pin_out,
  output wire logic       serial_out_pin_oe_out,
  output wire logic       serial_out_pin_weak_out,
  input  wire logic       primary_din_pin_in,
  input  wire logic       primary_bclk_pin_in,
  input  wire logic       primary_fsync_pin_in,
  input  wire logic       secondary_bclk_in,
  input  wire logic       secondary_fsync_in,
  // internal sources for the serial out pin
  input  wire logic       chip_irq_in,
  input  wire logic       pdm_clock_output_in,
  input  wire logic       general_clock_output_in,
  input  wire logic       primary_dout_in,
  input  wire logic       primary_dout2_in,
  input  wire logic       secondary_dout_in,
  input  wire logic       secondary_dout2_in,
  input  wire logic       secondary_bclk_gen_in,
  input  wire logic       secondary_fsync_gen_in,
  input  wire logic       muxed_pick_secondary_in,
  // routed signals
  output wire logic       chip_select_n_out,
  output wire logic       controller_clock_out,
  output wire logic       primary_second_din_out,
  output wire logic       primary_bclk_out,
  output wire logic       primary_fsync_out,
  output wire logic       loopback_din_out
);

  // ==================================================================
  // synchronised pin levels
  pfmg_pins_if pins ();

  assign pins.raw[`PFMG_SY_A]      = bidir_pin_a_in;
  assign pins.raw[`PFMG_SY_B]      = bidir_pin_b_in;
  assign pins.raw[`PFMG_SY_I]      = input_only_pin_in;
  assign pins.raw[`PFMG_SY_SOUT]   = serial_out_pin_in;
  assign pins.raw[`PFMG_SY_PDIN]   = primary_din_pin_in;
  assign pins.raw[`PFMG_SY_PBCLK]  = primary_bclk_pin_in;
  assign pins.raw[`PFMG_SY_PFSYNC] = primary_fsync_pin_in;
  assign pins.raw[`PFMG_SY_SBCLK]  = secondary_bclk_in;
  assign pins.raw[`PFMG_SY_SFSYNC] = secondary_fsync_in;

  // all pin inputs pass two flops before use
  pfmg_sync #(
    .WIDTH (`PFMG_SY_WIDTH)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pins       (pins)
  );

  // ==================================================================
  // state
  pfmg_pkg::pfmg_state_s state_reg;
  pfmg_pkg::pfmg_state_s state_next;

  // decoded pin conditions
  logic       in_only_active;
  logic       a_in_lvl;
  logic       b_in_lvl;
  logic       i_in_lvl;
  logic       sout_is_input;
  logic       fn_level;
  logic       fn_drives;
  logic [7:0] wr_val;

  // input-only pin usable as an input only outside SPI mode
  assign in_only_active = state_reg.in_pin_en & ~spi_mode_in;

  // monitor levels, zero when the pin is not an input
  assign a_in_lvl = bidir_a_is_gpi_in & pins.synced[`PFMG_SY_A];
  assign b_in_lvl = bidir_b_is_gpi_in & pins.synced[`PFMG_SY_B];
  assign i_in_lvl = in_only_active & pins.synced[`PFMG_SY_I];

  // serial out pin used as an input
  assign sout_is_input =
    (state_reg.sout_fn == pfmg_pkg::PFMG_FN_INPUT) ||
    (state_reg.sout_fn == pfmg_pkg::PFMG_FN_LOOPBACK);

  // ==================================================================
  // serial out pin function select
  always_comb begin
    fn_level  = 1'b0;
    fn_drives = 1'b1;
    case (state_reg.sout_fn)
      pfmg_pkg::PFMG_FN_GPO: begin
        fn_level = state_reg.sout_lvl;
      end
      pfmg_pkg::PFMG_FN_IRQ: begin
        fn_level = chip_irq_in;
      end
      pfmg_pkg::PFMG_FN_PDM_CLOCK_OUTPUT: begin
        fn_level = pdm_clock_output_in;
      end
      pfmg_pkg::PFMG_FN_PDOUT: begin
        fn_level = primary_dout_in;
      end
      pfmg_pkg::PFMG_FN_PDOUT2: begin
        fn_level = primary_dout2_in;
      end
      pfmg_pkg::PFMG_FN_SDOUT: begin
        fn_level = secondary_dout_in;
      end
      pfmg_pkg::PFMG_FN_SDOUT2: begin
        fn_level = secondary_dout2_in;
      end
      pfmg_pkg::PFMG_FN_SBCLK: begin
        fn_level = secondary_bclk_gen_in;
      end
      pfmg_pkg::PFMG_FN_SFSYNC: begin
        fn_level = secondary_fsync_gen_in;
      end
      pfmg_pkg::PFMG_FN_GENERAL_CLOCK_OUTPUT: begin
        fn_level = general_clock_output_in;
      end
      pfmg_pkg::PFMG_FN_MUXED: begin
        // one data line shared by both serial ports
        fn_level = muxed_pick_secondary_in ? secondary_dout_in
                                           : primary_dout_in;
      end
      default: begin
        // off, input, loopback input and reserved codes do not drive
        fn_drives = 1'b0;
      end
    endcase
  end

  // ==================================================================
  // register write data with reserved and read-only bits forced to zero
  always_comb begin
    wr_val = 8'h00;
    case (reg_addr_in)
      `PFMG_ADDR_IN_EN:   wr_val = reg_wdata_in & `PFMG_WMASK_IN_EN;
      `PFMG_ADDR_VALUES:  wr_val = reg_wdata_in & `PFMG_WMASK_VALUES;
      `PFMG_ADDR_ROUTING: wr_val = reg_wdata_in & `PFMG_WMASK_ROUTING;
      `PFMG_ADDR_SOUT:    wr_val = reg_wdata_in & `PFMG_WMASK_SOUT;
      default:            wr_val = 8'h00;
    endcase
  end

  // ==================================================================
  // next state
  always_comb begin
    state_next = state_reg;

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        `PFMG_ADDR_IN_EN: begin
          state_next.in_pin_en = wr_val[`PFMG_IN_EN_BIT];
        end
        `PFMG_ADDR_VALUES: begin
          state_next.a_lvl = wr_val[`PFMG_A_LVL_BIT];
          state_next.b_lvl = wr_val[`PFMG_B_LVL_BIT];
          state_next.o_lvl = wr_val[`PFMG_O_LVL_BIT];
        end
        `PFMG_ADDR_ROUTING: begin
          state_next.controller_clock_src  = wr_val[`PFMG_CONTROLLER_CLOCK_HI:`PFMG_CONTROLLER_CLOCK_LO];
          state_next.din2_src  = wr_val[`PFMG_DIN2_HI:`PFMG_DIN2_LO];
          state_next.bclk_src  = wr_val[`PFMG_BCLK_BIT];
          state_next.fsync_src = wr_val[`PFMG_FSYNC_BIT];
        end
        `PFMG_ADDR_SOUT: begin
          state_next.sout_fn  = pfmg_pkg::pfmg_sout_fn_e'(
                                  wr_val[`PFMG_FN_HI:`PFMG_FN_LO]);
          state_next.sout_lvl = wr_val[`PFMG_SLVL_BIT];
          state_next.sout_drv = pfmg_pkg::pfmg_drive_e'(
                                  wr_val[`PFMG_DRV_HI:`PFMG_DRV_LO]);
        end
        default: begin
          state_next.in_pin_en = state_reg.in_pin_en;
        end
      endcase
    end

    // read data, reserved bits zero, unmapped addresses zero
    state_next.rdata = 8'h00;
    case (reg_addr_in)
      `PFMG_ADDR_IN_EN: begin
        state_next.rdata[`PFMG_IN_EN_BIT] = state_reg.in_pin_en;
      end
      `PFMG_ADDR_VALUES: begin
        state_next.rdata[`PFMG_A_LVL_BIT] = state_reg.a_lvl;
        state_next.rdata[`PFMG_B_LVL_BIT] = state_reg.b_lvl;
        state_next.rdata[`PFMG_O_LVL_BIT] = state_reg.o_lvl;
        state_next.rdata[`PFMG_A_MON_BIT] = a_in_lvl;
        state_next.rdata[`PFMG_B_MON_BIT] = b_in_lvl;
        state_next.rdata[`PFMG_I_MON_BIT] = i_in_lvl;
      end
      `PFMG_ADDR_ROUTING: begin
        state_next.rdata[`PFMG_CONTROLLER_CLOCK_HI:`PFMG_CONTROLLER_CLOCK_LO] = state_reg.controller_clock_src;
        state_next.rdata[`PFMG_DIN2_HI:`PFMG_DIN2_LO] = state_reg.din2_src;
        state_next.rdata[`PFMG_BCLK_BIT]  = state_reg.bclk_src;
        state_next.rdata[`PFMG_FSYNC_BIT] = state_reg.fsync_src;
      end
      `PFMG_ADDR_SOUT: begin
        state_next.rdata[`PFMG_FN_HI:`PFMG_FN_LO] = state_reg.sout_fn;
        state_next.rdata[`PFMG_SLVL_BIT]          = state_reg.sout_lvl;
        state_next.rdata[`PFMG_DRV_HI:`PFMG_DRV_LO] = state_reg.sout_drv;
      end
      default: begin
        state_next.rdata = 8'h00;
      end
    endcase

    // general-purpose output pins
    state_next.a_pin = state_reg.a_lvl & bidir_a_is_gpo_in;
    state_next.a_oe  = bidir_a_is_gpo_in;
    state_next.b_pin = state_reg.b_lvl & bidir_b_is_gpo_in;
    state_next.b_oe  = bidir_b_is_gpo_in;
    state_next.o_pin = state_reg.o_lvl & output_only_is_gpo_in;
    state_next.o_oe  = output_only_is_gpo_in;

    // serial out pin level and drive style
    state_next.s_pin  = fn_level;
    state_next.s_oe   = 1'b0;
    state_next.s_weak = 1'b0;
    if (fn_drives) begin
      case (state_reg.sout_drv)
        pfmg_pkg::PFMG_DRV_PUSHPULL: begin
          state_next.s_oe = 1'b1;
        end
        pfmg_pkg::PFMG_DRV_LOW_WEAKH: begin
          state_next.s_oe   = 1'b1;
          state_next.s_weak = fn_level;
        end
        pfmg_pkg::PFMG_DRV_LOW_HIZH: begin
          state_next.s_oe = ~fn_level;
        end
        pfmg_pkg::PFMG_DRV_WEAKL_HI: begin
          state_next.s_oe   = 1'b1;
          state_next.s_weak = ~fn_level;
        end
        pfmg_pkg::PFMG_DRV_HIZL_HI: begin
          state_next.s_oe = fn_level;
        end
        default: begin
          // high impedance and reserved codes
          state_next.s_oe = 1'b0;
        end
      endcase
    end

    // controller clock source
    case (state_reg.controller_clock_src)
      2'h1:    state_next.controller_clock = pins.synced[`PFMG_SY_A];
      2'h2:    state_next.controller_clock = pins.synced[`PFMG_SY_B];
      2'h3:    state_next.controller_clock = i_in_lvl;
      default: state_next.controller_clock = 1'b0;
    endcase

    // primary second data input source
    case (state_reg.din2_src)
      3'h1:    state_next.din2 = pins.synced[`PFMG_SY_A];
      3'h2:    state_next.din2 = pins.synced[`PFMG_SY_B];
      3'h3:    state_next.din2 = i_in_lvl;
      3'h4:    state_next.din2 = sout_is_input &
                                 pins.synced[`PFMG_SY_SOUT];
      3'h5:    state_next.din2 = pins.synced[`PFMG_SY_PDIN];
      default: state_next.din2 = 1'b0;
    endcase

    // primary port bit clock and frame sync
    state_next.bclk  = state_reg.bclk_src ? pins.synced[`PFMG_SY_SBCLK]
                                          : pins.synced[`PFMG_SY_PBCLK];
    state_next.fsync = state_reg.fsync_src ? pins.synced[`PFMG_SY_SFSYNC]
                                           : pins.synced[`PFMG_SY_PFSYNC];

    // chip select follows the input-only pin in SPI mode
    state_next.cs_n = spi_mode_in ? pins.synced[`PFMG_SY_I] : 1'b1;

    // loopback input from the serial out pin
    state_next.loop_din =
      (state_reg.sout_fn == pfmg_pkg::PFMG_FN_LOOPBACK) &
      pins.synced[`PFMG_SY_SOUT];
  end

  // ==================================================================
  // state register with reset values
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_reg           <= '0;
      state_reg.in_pin_en <= 1'b0;
      state_reg.sout_fn   <= pfmg_pkg::pfmg_sout_fn_e'(
                               4'(`PFMG_RST_SOUT >> `PFMG_FN_LO));
      state_reg.sout_lvl  <= 1'b0;
      state_reg.sout_drv  <= pfmg_pkg::pfmg_drive_e'(
                               3'(`PFMG_RST_SOUT & 8'h07));
      state_reg.cs_n      <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==================================================================
  // outputs from the state register
  assign reg_rdata_out           = state_reg.rdata;
  assign bidir_pin_a_out         = state_reg.a_pin;
  assign bidir_pin_a_oe_out      = state_reg.a_oe;
  assign bidir_pin_b_out         = state_reg.b_pin;
  assign bidir_pin_b_oe_out      = state_reg.b_oe;
  assign output_only_pin_out     = state_reg.o_pin;
  assign output_only_pin_oe_out  = state_reg.o_oe;
  assign serial_out_pin_out      = state_reg.s_pin;
  assign serial_out_pin_oe_out   = state_reg.s_oe;
  assign serial_out_pin_weak_out = state_reg.s_weak;
  assign chip_select_n_out       = state_reg.cs_n;
  assign controller_clock_out    = state_reg.controller_clock;
  assign primary_second_din_out  = state_reg.din2;
  assign primary_bclk_out        = state_reg.bclk;
  assign primary_fsync_out       = state_reg.fsync;
  assign loopback_din_out        = state_reg.loop_din;

endmodule

// [pfmg_board.sv]
// pfmg_board.sv: board side of pin A, pin B and the serial out pin.
// assumes: the bench sets the level each line takes when released.
`timescale 1ns/1ps
module pfmg_board (
  input  wire logic [2:0] oe_in,
  input  wire logic [2:0] drv_in,
  input  wire logic [2:0] ext_in,
  output wire logic [2:0] wire_out
);
  // a released line takes the board level, a driven one the device level
  assign wire_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule

// [pfmg_top_monitor.sv]
// pfmg_top_monitor.sv: port-level checks of the pin block.
// assumes: bound to pfmg_top; pin inputs pass two flops and a state flop.
`timescale 1ns/1ps
module pfmg_top_monitor (
  input wire logic       ref_clk_in,
  input wire logic       reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       spi_mode_in,
  input wire logic       bidir_a_is_gpo_in,
  input wire logic       output_only_is_gpo_in,
  input wire logic       bidir_pin_a_out,
  input wire logic       output_only_pin_out,
  input wire logic       input_only_pin_in,
  input wire logic       chip_select_n_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  property p_cs_spi;
    (spi_mode_in && $stable(input_only_pin_in))[*4]
      |-> chip_select_n_out == input_only_pin_in;
  endproperty
  a_cs_spi: assert property (p_cs_spi) else $error("cs level");
  property p_cs_off;
    (!spi_mode_in)[*4] |-> chip_select_n_out;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("cs idle");
  property p_lvl_a;
    reg_wr_in && reg_addr_in == 8'h0e ##1 !reg_wr_in && bidir_a_is_gpo_in
      |=> bidir_pin_a_out == $past(reg_wdata_in[7], 2);
  endproperty
  a_lvl_a: assert property (p_lvl_a) else $error("pin a level");
  property p_lvl_o;
    reg_wr_in && reg_addr_in == 8'h0e ##1 !reg_wr_in && output_only_is_gpo_in
      |=> output_only_pin_out == $past(reg_wdata_in[5], 2);
  endproperty
  a_lvl_o: assert property (p_lvl_o) else $error("out pin level");
  property p_a_off;
    (!bidir_a_is_gpo_in)[*2] |-> !bidir_pin_a_out;
  endproperty
  a_a_off: assert property (p_a_off) else $error("pin a off");
  property p_o_off;
    (!output_only_is_gpo_in)[*2] |-> !output_only_pin_out;
  endproperty
  a_o_off: assert property (p_o_off) else $error("out pin off");
  property p_unmapped;
    !(reg_addr_in inside {[8'h0d:8'h10]}) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_rsvd;
    reg_addr_in == 8'h0e |=> (reg_rdata_out & 8'h11) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
endmodule

bind pfmg_top pfmg_top_monitor pfmg_top_monitor_inst (.ref_clk_in,
  .reset_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
  .spi_mode_in, .bidir_a_is_gpo_in, .output_only_is_gpo_in,
  .bidir_pin_a_out, .output_only_pin_out, .input_only_pin_in,
  .chip_select_n_out);

// [pfmg_top_bench.sv]
// pfmg_top_bench.sv: register and pin scenarios for the pin block.
// assumes: design, board model and checker are compiled first.
`timescale 1ns/1ps
module pfmg_top_bench;
  logic       ref_clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       wr = 1'b0;
  logic       spi = 1'b0;
  logic       pick = 1'b0;
  logic       oe_x;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] v;
  logic [4:0] g = 5'h00;
  logic [4:0] e = 5'h00;
  logic [3:0] k = 4'h0;
  logic [8:0] s = 9'h000;
  wire  [7:0] rdata;
  wire  [2:0] oe, dv, w;
  wire        o_o, o_oe, s_wk, cs_n, controller_clock, din2, bclk, fs, lpb;
  int         n_fail = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h00, 8'h52, 8'h00};
  logic [7:0] msk [5] = '{8'h02, 8'he0, 8'h7f, 8'hff, 8'h00};
  logic [3:0] fn [11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha,
                          4'hb, 4'hc, 4'hc};
  int         ln [11] = '{0, 1, 3, 4, 5, 6, 7, 8, 2, 3, 5};
  logic [3:0] offc [5] = '{4'h0, 4'h1, 4'hd, 4'he, 4'hf};

  pfmg_top pfmg_top_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .spi_mode_in(spi), .bidir_a_is_gpo_in(g[4]), .bidir_a_is_gpi_in(g[3]),
    .bidir_b_is_gpo_in(g[2]), .bidir_b_is_gpi_in(g[1]),
    .output_only_is_gpo_in(g[0]), .bidir_pin_a_in(w[0]),
    .bidir_pin_a_out(dv[0]), .bidir_pin_a_oe_out(oe[0]),
    .bidir_pin_b_in(w[1]), .bidir_pin_b_out(dv[1]),
    .bidir_pin_b_oe_out(oe[1]), .output_only_pin_out(o_o),
    .output_only_pin_oe_out(o_oe), .input_only_pin_in(e[2]),
    .serial_out_pin_in(w[2]), .serial_out_pin_out(dv[2]),
    .serial_out_pin_oe_out(oe[2]), .serial_out_pin_weak_out(s_wk),
    .primary_din_pin_in(e[4]), .primary_bclk_pin_in(k[3]),
    .primary_fsync_pin_in(k[2]), .secondary_bclk_in(k[1]),
    .secondary_fsync_in(k[0]), .chip_irq_in(s[0]),
    .pdm_clock_output_in(s[1]), .general_clock_output_in(s[2]),
    .primary_dout_in(s[3]), .primary_dout2_in(s[4]),
    .secondary_dout_in(s[5]), .secondary_dout2_in(s[6]),
    .secondary_bclk_gen_in(s[7]), .secondary_fsync_gen_in(s[8]),
    .muxed_pick_secondary_in(pick), .chip_select_n_out(cs_n),
    .controller_clock_out(controller_clock), .primary_second_din_out(din2),
    .primary_bclk_out(bclk), .primary_fsync_out(fs),
    .loopback_din_out(lpb));
  pfmg_board pfmg_board_inst (.oe_in(oe), .drv_in(dv),
    .ext_in({e[3], e[1], e[0]}), .wire_out(w));

  // clock and hang guard
  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // register port cycles, one write pulse per wr_reg call, none per rd_reg call
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  task automatic settle;
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    settle();
    d = rdata;
  endtask
  task automatic finish_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // scenarios
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd_reg(8'h0d + 8'(i), v);
      chk("reset", v, rst[i]);
      wr_reg(8'h0d + 8'(i), msk[i]);
      rd_reg(8'h0d + 8'(i), v);
      chk("mask", v, msk[i]);
    end
    for (int i = 0; i < 2; i++) begin
      wr_reg(8'h0e, i ? 8'ha0 : 8'h40);
      g <= 5'b10101;
      settle();
      chk("gpo", {o_oe, oe[1:0], o_o, dv[1:0]},
        i ? 6'h3d : 6'h3a);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h0d, i == 1 ? 8'h00 : 8'h02);
      g <= 5'b01010;
      e <= i == 2 ? 5'b00001 : 5'b00101;
      spi <= (i == 2);
      rd_reg(8'h0e, v);
      chk("monitor", v, i == 0 ? 8'haa : 8'ha8);
      chk("cs", cs_n, i != 2);
    end
    wr_reg(8'h10, 8'h12);
    spi <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h0f, {1'b0, c < 4 ? 2'(c) : 2'b00, 3'(c), 2'b00});
      e <= (c >= 1 && c <= 5) ? 5'(1 << (c - 1)) : 5'h1f;
      settle();
      chk("din2", din2, c >= 1 && c <= 5);
      chk("controller_clock", controller_clock, c >= 1 && c <= 3);
    end
    for (int r = 0; r < 4; r++) begin
      wr_reg(8'h0f, 8'(r));
      k <= 4'b0110;
      settle();
      chk("bclk/fsync", {bclk, fs}, {r[1], !r[0]});
    end
    for (int j = 0; j < 11; j++) begin
      wr_reg(8'h10, {fn[j], 4'h1});
      for (int h = 0; h < 2; h++) begin
        s <= h ? ~(9'h001 << ln[j]) : (9'h001 << ln[j]);
        pick <= (j == 10);
        settle();
        chk("function", {oe[2], dv[2]}, {1'b1, h == 0});
        @(posedge ref_clk_in);
      end
    end
    foreach (offc[j]) begin
      wr_reg(8'h10, {offc[j], 4'h1});
      e <= 5'h08;
      settle();
      chk("off/loop", {oe[2], lpb}, {1'b0, offc[j] == 4'hd});
    end
    for (int d = 0; d < 8; d++) begin
      for (int l = 0; l < 2; l++) begin
        wr_reg(8'h10, {4'h2, 1'(l), 3'(d)});
        settle();
        oe_x = d inside {1, 2, 4} || (d == 3 && l == 0) || (d == 5 && l == 1);
        chk("drive", oe[2], oe_x);
        if (oe_x) chk("level", {s_wk, dv[2]},
          {(d == 2 && l == 1) || (d == 4 && l == 0), 1'(l)});
      end
    end
    finish_test();
  end
endmodule
